// File: verilog/nip_pkg.sv
package nip_pkg;
    // Slot and level geometry
    localparam int NUM_SLOTS = 14;
    localparam int NUM_PAIRS = 16;
    localparam int SLOT_W = 4;
    localparam int ADDR_W = 12;
    localparam int DEPTH_W = 4;

    // Two-bit priority codes as held in the condition code
    localparam logic [1:0] CODE_L0 = 2'h2;
    localparam logic [1:0] CODE_L1 = 2'h1;
    localparam logic [1:0] CODE_L2 = 2'h0;
    localparam logic [1:0] CODE_L3 = 2'h3;

    // Slots that exist, slots that end halt, slots that end active halt
    localparam logic [NUM_SLOTS-1:0] VALID_MASK = 14'h3FBE;
    localparam logic [NUM_SLOTS-1:0] HALT_WAKE_MASK = 14'h00BE;
    localparam logic [NUM_SLOTS-1:0] AHALT_WAKE_MASK = 14'h0002;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_CC = 8'h20;
    localparam logic [7:0] IDX_CTRL = 8'h21;
    localparam logic [7:0] IDX_VPRIO0 = 8'h24;
    localparam logic [7:0] IDX_VPRIO3 = 8'h27;

    // Condition code layout and reset values
    localparam logic [7:0] CC_FIXED = 8'hC2;
    localparam int CC_HI_BIT = 5;
    localparam int CC_LO_BIT = 3;
    localparam logic [7:0] VPRIO_RESET = 8'hFF;
    localparam logic [7:0] VPRIO3_RO_MASK = 8'hF0;
    localparam logic [7:0] CTRL_RESET = 8'h01;
    localparam int CTRL_NESTED_BIT = 0;

    // Vector addresses
    localparam logic [15:0] VEC_BASE = 16'hFFFA;
    localparam logic [15:0] VEC_TRAP = 16'hFFFC;

    // Power states, Gray along run-wait-halt-active halt
    typedef enum logic [1:0] {
        NIP_RUN = 2'h0,
        NIP_WAIT = 2'h1,
        NIP_HALT = 2'h3,
        NIP_AHALT = 2'h2
    } nip_pwr_t;

    // Instruction strobes from the CPU core
    typedef struct packed {
        logic enable_irq_instr;
        logic sim;
        logic wait_for_irq_instr;
        logic halt;
        logic active_halt;
        logic irq_return_instr;
        logic pop_cc;
        logic trap;
        logic [1:0] pop_prio;
    } nip_instr_t;

    // Service request handed to the CPU core
    typedef struct packed {
        logic trap;
        logic [SLOT_W-1:0] slot;
        logic [15:0] addr;
        logic [1:0] saved_prio;
    } nip_svc_t;

    // Code to numeric level, 0 lowest
    function automatic logic [1:0] nip_code2lvl(input logic [1:0] code);
        logic [1:0] lvl;
        lvl = 2'h0;
        unique case (code)
            CODE_L0: lvl = 2'h0;
            CODE_L1: lvl = 2'h1;
            CODE_L2: lvl = 2'h2;
            CODE_L3: lvl = 2'h3;
        endcase
        return lvl;
    endfunction
endpackage

// File: verilog/nip_top.sv
// Function
// - Any pending request ends the WAIT state.
// - Only wake-capable sources end HALT; timers, serial comms, voltage detector cannot.
// - First service after HALT goes to a wake-capable source; others follow.
// - Active halt ends only by reset or clock time-base request.
// - Concurrent mode never pre-empts a handler; nested mode pre-empts on higher level.
// - Fixed hardware priority falls as slot number rises.
// - Current level sits in condition-code bits 5 and 3, reset to level 3.
// - Codes: level0=10, level1=01, level2=00, level3=11.
// - Entering a handler loads the serviced slot's stored level.
// - Reset and trap are taken even at level 3.
// - Reset and trap have no stored level and set both bits.
// - Four priority registers reset to ones; top nibble of the fourth reads ones.
// - Pair x belongs to the vector at descending address pair x.
// - Writing the level-0 code into a pair is ignored for that pair.
// - Raising own level while pending re-enters, else applies at next request.
// - Enable loads 10, disable loads 11, halt and wait load 10.
// - Interrupt return restores the level popped from the stack.
// - Two jump conditions test level bits equal to or differing from 11.
// - Halt, pop, enable, disable and wait change level inside a handler.
// - No stack overflow indication; nesting depth is software's problem.
// - Highest software level served first, ties by hardware order.
// - Unserviceable requests stay latched pending.
// - Service after the current instruction, push context, then load the vector.
`timescale 1ns/1ps
module nip_top
#(
    parameter int DEPTH_W_P = nip_pkg::DEPTH_W
)
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [nip_pkg::ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // CPU core side
    input wire logic instr_end_i,
    input wire nip_pkg::nip_instr_t instr_i,
    input wire logic [nip_pkg::NUM_SLOTS-1:0] irq_req_i,
    output nip_pkg::nip_svc_t svc_o,
    output logic svc_valid_o,
    output logic wake_o,
    output logic [1:0] prio_bits_o,
    output logic jump_if_masked_o,
    output logic jump_if_unmasked_o,
    output logic [1:0] power_state_o
);
    import nip_pkg::*;

    logic [1:0] cc_prio_reg;
    logic [1:0] cc_prio_next;
    logic [7:0] ctrl_reg;
    logic [7:0] vprio_reg [4];
    logic [7:0] vprio_next [4];
    logic [NUM_SLOTS-1:0] pend_reg;
    logic [NUM_SLOTS-1:0] pend_next;
    logic [DEPTH_W_P-1:0] depth_reg;
    logic [DEPTH_W_P-1:0] depth_next;
    nip_pwr_t pwr_reg;
    nip_pwr_t pwr_next;
    logic halt_first_reg;
    logic halt_first_next;
    logic pready_reg;
    logic pslverr_reg;
    logic [31:0] prdata_reg;
    nip_svc_t svc_reg;
    logic svc_valid_reg;
    logic wake_reg;
    logic jm_reg;
    logic jnm_reg;

    // APB decode
    wire [7:0] acc_idx = paddr_i[9:2];
    wire acc_hi_zero = (paddr_i[ADDR_W-1:10] == '0) && (paddr_i[1:0] == 2'h0);
    wire hit_cc = acc_hi_zero && (acc_idx == IDX_CC);
    wire hit_ctrl = acc_hi_zero && (acc_idx == IDX_CTRL);
    wire hit_vprio = acc_hi_zero && (acc_idx >= IDX_VPRIO0) && (acc_idx <= IDX_VPRIO3);
    wire [1:0] vprio_sel = 2'(acc_idx - IDX_VPRIO0);
    wire mapped = hit_cc || hit_ctrl || hit_vprio;
    wire apb_setup = psel_i && !penable_i;
    wire apb_wr = psel_i && penable_i && pready_reg && pwrite_i && mapped;
    wire nested_en = ctrl_reg[CTRL_NESTED_BIT];

    // Read mux, CC shows its fixed bits around the level pair
    wire [7:0] cc_view = CC_FIXED | {2'h0, cc_prio_reg[1], 1'b0, cc_prio_reg[0], 3'h0};
    wire [7:0] rd_byte = hit_cc ? cc_view : hit_ctrl ? ctrl_reg : hit_vprio ? vprio_reg[vprio_sel] : 8'h00;

    // Per-slot level and eligibility
    wire [1:0] cur_lvl = nip_code2lvl(cc_prio_reg);
    logic [1:0] slot_code [NUM_SLOTS];
    logic [1:0] slot_lvl [NUM_SLOTS];
    logic [NUM_SLOTS-1:0] elig;
    logic [1:0] pair_next [NUM_PAIRS];
    wire [NUM_SLOTS-1:0] wake_filter = halt_first_reg ? HALT_WAKE_MASK : VALID_MASK;

    genvar g;
    generate
        for (g = 0; g < NUM_PAIRS; g++)
        begin : g_pair
            wire [1:0] old_pair = vprio_reg[g/4][2*(g%4)+:2];
            wire [1:0] new_pair = pwdata_i[2*(g%4)+:2];
            wire pair_wr = apb_wr && hit_vprio && (vprio_sel == 2'(g/4)) && (g < NUM_SLOTS);
            // Level-0 code is refused per pair, neighbours still update
            assign pair_next[g] = (pair_wr && new_pair != CODE_L0) ? new_pair : old_pair;
            if (g < NUM_SLOTS)
            begin : g_slot
                assign slot_code[g] = old_pair;
                assign slot_lvl[g] = nip_code2lvl(old_pair);
                // Live level compare lets a raised own level re-enter
                assign elig[g] = pend_reg[g] && VALID_MASK[g] && wake_filter[g]
                    && (slot_lvl[g] > cur_lvl);
            end
        end
        for (g = 0; g < 4; g++)
        begin : g_byte
            assign vprio_next[g] = {pair_next[4*g+3], pair_next[4*g+2], pair_next[4*g+1], pair_next[4*g]};
        end
    endgenerate

    // Arbitration: highest level, then lowest slot number
    logic found;
    logic [SLOT_W-1:0] best_idx;
    logic [1:0] best_lvl;
    always_comb
    begin
        found = 1'b0;
        best_idx = '0;
        best_lvl = 2'h0;
        for (int i = NUM_SLOTS - 1; i >= 0; i--)
        begin
            if (elig[i] && (!found || slot_lvl[i] >= best_lvl))
            begin
                found = 1'b1;
                best_idx = SLOT_W'(i);
                best_lvl = slot_lvl[i];
            end
        end
    end
    wire [1:0] best_code = slot_code[best_idx];

    // Service decisions, taken only at an instruction boundary
    wire in_run = (pwr_reg == NIP_RUN);
    wire take_trap = in_run && instr_end_i && instr_i.trap;
    wire may_preempt = nested_en || (depth_reg == '0);
    wire take_mask = in_run && instr_end_i && !instr_i.trap && found && may_preempt;
    wire [NUM_SLOTS-1:0] ack_mask = take_mask ? (NUM_SLOTS'(1) << best_idx) : '0;
    wire [NUM_SLOTS-1:0] pend_keep = pend_reg & ~ack_mask;
    wire [15:0] slot_addr = VEC_BASE - {11'h000, best_idx, 1'b0};

    // New requests win over the acknowledge in the same cycle
    assign pend_next = pend_keep | (irq_req_i & VALID_MASK);

    // Current level: service beats return or pop, beats the mask instructions
    always_comb
    begin
        cc_prio_next = cc_prio_reg;
        if (take_trap)
            cc_prio_next = CODE_L3;
        else if (take_mask)
            cc_prio_next = best_code;
        else if (instr_i.irq_return_instr || instr_i.pop_cc)
            cc_prio_next = instr_i.pop_prio;
        else if (instr_i.sim)
            cc_prio_next = CODE_L3;
        else if (instr_i.enable_irq_instr || instr_i.wait_for_irq_instr || instr_i.halt)
            cc_prio_next = CODE_L0;
        else if (apb_wr && hit_cc)
            cc_prio_next = {pwdata_i[CC_HI_BIT], pwdata_i[CC_LO_BIT]};
    end

    // Wake conditions per low-power state
    wire wake_wait = |(pend_reg & VALID_MASK);
    wire wake_halt = |(pend_reg & HALT_WAKE_MASK);
    wire wake_ahalt = |(pend_reg & AHALT_WAKE_MASK);
    logic wake_now;
    always_comb
    begin
        pwr_next = pwr_reg;
        wake_now = 1'b0;
        unique case (pwr_reg)
            NIP_RUN:
            begin
                if (instr_i.wait_for_irq_instr)
                    pwr_next = NIP_WAIT;
                else if (instr_i.halt)
                    pwr_next = instr_i.active_halt ? NIP_AHALT : NIP_HALT;
            end
            NIP_WAIT:
                wake_now = wake_wait;
            NIP_HALT:
                wake_now = wake_halt;
            NIP_AHALT:
                wake_now = wake_ahalt;
        endcase
        if (wake_now)
            pwr_next = NIP_RUN;
    end

    // First service after halt is restricted to wake sources
    assign halt_first_next = (wake_now && pwr_reg != NIP_WAIT) ? 1'b1
        : (take_mask || take_trap) ? 1'b0 : halt_first_reg;

    // Depth saturates silently, software bounds nesting itself
    always_comb
    begin
        depth_next = depth_reg;
        if ((take_mask || take_trap) && !instr_i.irq_return_instr && depth_reg != '1)
            depth_next = depth_reg + DEPTH_W_P'(1);
        else if (instr_i.irq_return_instr && !(take_mask || take_trap) && depth_reg != '0)
            depth_next = depth_reg - DEPTH_W_P'(1);
    end

    // Control state
    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
        begin
            cc_prio_reg <= CODE_L3;
            ctrl_reg <= CTRL_RESET;
            for (int i = 0; i < 4; i++)
                vprio_reg[i] <= VPRIO_RESET;
            pend_reg <= '0;
            depth_reg <= '0;
            pwr_reg <= NIP_RUN;
            halt_first_reg <= 1'b0;
        end
        else
        begin
            cc_prio_reg <= cc_prio_next;
            if (apb_wr && hit_ctrl)
                ctrl_reg <= {7'h00, pwdata_i[CTRL_NESTED_BIT]};
            for (int i = 0; i < 3; i++)
                vprio_reg[i] <= vprio_next[i];
            vprio_reg[3] <= vprio_next[3] | VPRIO3_RO_MASK;
            pend_reg <= pend_next;
            depth_reg <= depth_next;
            pwr_reg <= pwr_next;
            halt_first_reg <= halt_first_next;
        end
    end

    // APB answer: one access cycle, errors on unmapped addresses
    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
        begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= '0;
        end
        else
        begin
            pready_reg <= apb_setup;
            pslverr_reg <= apb_setup && !mapped;
            prdata_reg <= apb_setup ? {24'h000000, rd_byte} : 32'h00000000;
        end
    end

    // CPU-facing outputs, all registered
    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
        begin
            svc_reg <= '0;
            svc_valid_reg <= 1'b0;
            wake_reg <= 1'b0;
            jm_reg <= 1'b1;
            jnm_reg <= 1'b0;
        end
        else
        begin
            svc_valid_reg <= take_trap || take_mask;
            if (take_trap || take_mask)
                svc_reg <= '{trap: take_trap, slot: take_trap ? SLOT_W'(0) : best_idx,
                    addr: take_trap ? VEC_TRAP : slot_addr, saved_prio: cc_prio_reg};
            wake_reg <= wake_now;
            jm_reg <= (cc_prio_next == CODE_L3);
            jnm_reg <= (cc_prio_next != CODE_L3);
        end
    end

    assign prdata_o = prdata_reg;
    assign pready_o = pready_reg;
    assign pslverr_o = pslverr_reg;
    assign svc_o = svc_reg;
    assign svc_valid_o = svc_valid_reg;
    assign wake_o = wake_reg;
    assign prio_bits_o = cc_prio_reg;
    assign jump_if_masked_o = jm_reg;
    assign jump_if_unmasked_o = jnm_reg;
    assign power_state_o = pwr_reg;

    // Checks
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);

    wait_wake_a: assert property (pwr_reg == NIP_WAIT && wake_wait |=> pwr_reg == NIP_RUN ##0 wake_o)
        else $error("wait not ended by pending request");
    halt_hold_a: assert property (pwr_reg == NIP_HALT && !wake_halt |=> pwr_reg == NIP_HALT)
        else $error("halt ended by non-wake source");
    ahalt_hold_a: assert property (pwr_reg == NIP_AHALT && !pend_reg[1] |=> pwr_reg == NIP_AHALT)
        else $error("active halt ended by wrong source");
    halt_first_a: assert property (take_mask && halt_first_reg |-> HALT_WAKE_MASK[best_idx])
        else $error("first service after halt not wake capable");
    no_preempt_a: assert property (take_mask && !nested_en |-> depth_reg == '0)
        else $error("concurrent mode pre-empted a handler");
    level_load_a: assert property (take_mask |=> cc_prio_reg == $past(best_code) ##0 svc_valid_o)
        else $error("handler level not loaded from slot");
    trap_level_a: assert property (take_trap |=> cc_prio_reg == CODE_L3 ##0 svc_o.addr == VEC_TRAP)
        else $error("trap did not set level 3");
    level0_keep_a: assert property (apb_wr && hit_vprio && vprio_sel == 2'h1 && pwdata_i[3:2] == CODE_L0
        |=> vprio_reg[1][3:2] == $past(vprio_reg[1][3:2]))
        else $error("level 0 code was stored");
    rim_level_a: assert property (instr_i.enable_irq_instr && !take_trap && !take_mask && !instr_i.irq_return_instr && !instr_i.pop_cc
        && !instr_i.sim |=> cc_prio_reg == CODE_L0)
        else $error("enable did not load level 0");
    jump_flag_a: assert property (##1 jump_if_masked_o == (cc_prio_reg == CODE_L3)
        && jump_if_unmasked_o == !jump_if_masked_o)
        else $error("jump condition does not match level");
    pend_hold_a: assert property (##1 (($past(pend_keep) & ~pend_reg) == '0))
        else $error("pending request lost");
    unused_slot_a: assert property (!pend_reg[0] && !pend_reg[6] && !(take_mask && (best_idx == 4'h0
        || best_idx == 4'h6)))
        else $error("unused slot became pending");

    // Active-halt exit, wake pulse width, vector address and read-only nibble
    ahalt_wake_a: assert property (pwr_reg == NIP_AHALT && pend_reg[1] |=> pwr_reg == NIP_RUN ##0 wake_o)
        else $error("active halt not ended by time-base request");
    wake_pulse_a: assert property (wake_o |=> !wake_o)
        else $error("wake pulse longer than one cycle");
    svc_addr_a: assert property (take_mask |=> svc_o.addr == VEC_BASE - {11'h000, svc_o.slot, 1'b0})
        else $error("vector address does not match slot");
    ro_nibble_a: assert property (vprio_reg[3][7:4] == 4'hF)
        else $error("read-only nibble lost its ones");

    trap_c: cover property (take_trap);
    nest_c: cover property (take_mask && depth_reg != '0);
    halt_wake_c: cover property (pwr_reg == NIP_HALT ##1 pwr_reg == NIP_RUN ##[1:20] take_mask);
    irq_return_instr_c: cover property (instr_i.irq_return_instr && depth_reg != '0);
    wait_wake_c: cover property (pwr_reg == NIP_WAIT ##1 wake_o);
endmodule

// File: test/nip_cpu_model.sv
`timescale 1ns/1ps
module nip_cpu_model
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_i,
    // Requests of the bench
    input wire nip_pkg::nip_instr_t cmd_i,
    input wire logic stall_i,
    // Answers of the block
    input wire nip_pkg::nip_svc_t svc_i,
    input wire logic svc_valid_i,
    // Core side of the block
    output logic instr_end_o,
    output nip_pkg::nip_instr_t instr_o
);
    import nip_pkg::*;
    logic [1:0] stack_reg [0:31];
    logic [4:0] sp_reg;

    // Stalls stretch an instruction; no depth limit, wraps silently
    assign instr_end_o = !reset_i && !stall_i;

    // Return pops the level saved at entry
    always_comb
    begin
        instr_o = cmd_i;
        if (cmd_i.irq_return_instr)
            instr_o.pop_prio = stack_reg[sp_reg - 5'h1];
    end

    // Entry pushes the context with its level
    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
            sp_reg <= 5'h0;
        else if (svc_valid_i)
        begin
            stack_reg[sp_reg] <= svc_i.saved_prio;
            sp_reg <= sp_reg + 5'h1;
        end
        else if (cmd_i.irq_return_instr)
            sp_reg <= sp_reg - 5'h1;
    end
endmodule

// File: test/testbench.sv
`timescale 1ns/1ps
module testbench;
    import nip_pkg::*;
    // Instruction strobes as bit patterns of the instruction struct
    localparam logic [9:0] I_RIM = 10'h200;
    localparam logic [9:0] I_SIM = 10'h100;
    localparam logic [9:0] I_WFI = 10'h080;
    localparam logic [9:0] I_HALT = 10'h040;
    localparam logic [9:0] I_AHALT = 10'h060;
    localparam logic [9:0] I_IRQ_RETURN_INSTR = 10'h010;
    localparam logic [9:0] I_TRAP = 10'h004;
    logic clk_sys_i = 1'b0;
    logic reset_i = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slow = 1'b0, stall = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic [13:0] irq = 14'h0;
    nip_instr_t cmd = '0;
    nip_instr_t instr;
    nip_svc_t svc;
    logic [31:0] prdata, rd, vp;
    logic pready, pslverr, err, instr_end, svc_valid, wake, jm, jnm;
    logic [1:0] prio, pwr;
    logic [13:0] pend;
    logic [7:0] wv;
    int failures = 0;
    int n_compared = 0;
    int w;

    nip_top u_nip_top (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .instr_end_i(instr_end), .instr_i(instr), .irq_req_i(irq), .svc_o(svc),
        .svc_valid_o(svc_valid), .wake_o(wake), .prio_bits_o(prio), .jump_if_masked_o(jm),
        .jump_if_unmasked_o(jnm), .power_state_o(pwr));
    nip_cpu_model u_nip_cpu_model (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .cmd_i(cmd),
        .stall_i(stall), .svc_i(svc), .svc_valid_i(svc_valid), .instr_end_o(instr_end), .instr_o(instr));

    // Clock, and random core stalls while slow is set
    always #10 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) stall <= slow && ($urandom_range(1, 0) == 1);

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            failures++;
            $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One APB transfer; waits for pready, then an idle cycle
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= {24'h0, d};
        @(posedge clk_sys_i);
        penable <= 1'b1;
        // Only the watchdog ends a wait for the answer
        @(posedge clk_sys_i);
        while (pready !== 1'b1)
            @(posedge clk_sys_i);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys_i);
    endtask

    task automatic apr(input logic [7:0] idx, input logic [7:0] exp);
        apb(1'b0, idx, 8'h0);
        chk(rd, {24'h0, exp});
        chk(err, 1'b0);
    endtask

    task automatic ins(input logic [9:0] v);
        cmd <= v;
        @(posedge clk_sys_i);
        cmd <= '0;
        @(posedge clk_sys_i);
    endtask

    task automatic irqp(input logic [13:0] m);
        irq <= m;
        @(posedge clk_sys_i);
        irq <= 14'h0;
    endtask

    // Waits for a service or, with s of -2, a wake-up
    task automatic wsvc(input int s, input logic [1:0] code);
        int n;
        n = 0;
        while ((s == -2 ? wake : svc_valid) !== 1'b1 && n < 60)
        begin
            @(posedge clk_sys_i);
            n++;
        end
        if (s == -2)
            chk({wake, pwr}, 3'h4);
        else
            chk({svc_valid, svc.addr, prio}, {1'b1, 16'hFFFA - 16'(2 * s), code});
        if (s >= 0)
            chk(svc.slot, s[3:0]);
        @(posedge clk_sys_i);
    endtask

    task automatic quiet();
        repeat (8)
        begin
            @(posedge clk_sys_i);
            chk(svc_valid | wake, 1'b0);
        end
    endtask

    task automatic rst();
        reset_i <= 1'b1;
        repeat (6) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        @(posedge clk_sys_i);
    endtask

    // Highest level wins, ties go to the lower slot; slots 0 and 6 never
    function automatic int winner(input logic [13:0] p, input logic [31:0] v);
        int best, bl, l;
        best = -1;
        bl = 0;
        for (int s = 1; s < 14; s++)
        begin
            l = int'({v[2*s+1] == v[2*s], v[2*s]});
            if (p[s] && s != 6 && l > bl)
            begin
                best = s;
                bl = l;
            end
        end
        return best;
    endfunction

    task automatic tally_and_finish();
        $display("Compared %0d values, %0d wrong", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        void'($urandom(32'hAE4D));
        rst();
        chk({prio, jm, jnm, pwr}, 6'h38);
        apr(IDX_CC, 8'hEA);
        apr(IDX_CTRL, 8'h01);
        for (int r = 0; r < 4; r++)
            apr(IDX_VPRIO0 + 8'(r), 8'hFF);
        apb(1'b0, 8'h00, 8'h0);
        chk(rd, 32'h0);
        chk(err, 1'b1);
        apb(1'b1, IDX_VPRIO0 + 8'h1, 8'hCF);
        apb(1'b1, IDX_VPRIO0 + 8'h1, 8'h64);
        apr(IDX_VPRIO0 + 8'h1, 8'h44);
        apb(1'b1, IDX_VPRIO3, 8'h00);
        apr(IDX_VPRIO3, 8'hF0);
        ins(I_RIM);
        chk({prio, jm, jnm}, 4'h9);
        ins(I_SIM);
        chk({prio, jm, jnm}, 4'hE);
        ins(I_TRAP);
        wsvc(-1, 2'h3);
        chk({svc.trap, svc.saved_prio}, 3'h7);
        // Random levels and requests latched at level 3, then released
        repeat (12)
        begin
            rst();
            for (int r = 0; r < 4; r++)
            begin
                wv = 8'($urandom);
                apb(1'b1, IDX_VPRIO0 + 8'(r), wv);
                for (int p = 0; p < 4; p++)
                    if (wv[2*p+:2] == 2'h2 || r == 3 && p > 1) wv[2*p+:2] = 2'h3;
                vp[8*r+:8] = wv;
                apr(IDX_VPRIO0 + 8'(r), wv);
            end
            pend = 14'($urandom) | 14'h0800;
            irqp(pend);
            quiet();
            slow <= 1'b1;
            ins(I_RIM);
            w = winner(pend, vp);
            wsvc(w, vp[2*w+:2]);
            slow <= 1'b0;
        end
        // Concurrent then nested handling of a higher request
        for (int m = 0; m < 2; m++)
        begin
            rst();
            apb(1'b1, IDX_CTRL, 8'(m));
            apb(1'b1, IDX_VPRIO0 + 8'h2, 8'hFD);
            ins(I_RIM);
            irqp(14'h0100);
            wsvc(8, 2'h1);
            irqp(14'h0004);
            if (m == 0)
                quiet();
            if (m == 0)
                ins(I_IRQ_RETURN_INSTR);
            wsvc(2, 2'h3);
            chk(svc.saved_prio, m == 0 ? 2'h2 : 2'h1);
            ins(I_IRQ_RETURN_INSTR);
            chk(prio, m == 0 ? 2'h2 : 2'h1);
        end
        // Pop of the condition code inside a handler, then a software write of the level
        ins(10'h008);
        chk({prio, jm, jnm}, 4'h1);
        apb(1'b1, IDX_CC, 8'h20);
        apr(IDX_CC, 8'hE2);
        rst();
        ins(I_WFI);
        chk({pwr, prio}, 4'h6);
        irqp(14'h0800);
        wsvc(-2, 2'h0);
        rst();
        apb(1'b1, IDX_VPRIO0, 8'h7F);
        ins(I_HALT);
        chk({pwr, prio}, 4'hE);
        irqp(14'h0100);
        quiet();
        irqp(14'h0008);
        wsvc(-2, 2'h0);
        wsvc(3, 2'h1);
        wsvc(8, 2'h3);
        rst();
        ins(I_AHALT);
        chk(pwr, 2'h2);
        irqp(14'h0004);
        quiet();
        irqp(14'h0002);
        wsvc(-2, 2'h0);
        tally_and_finish();
    end

    // Run needs some 800 cycles; a hang is cut off well beyond that
    initial
    begin
        #600000;
        failures++;
        tally_and_finish();
    end
endmodule
